// *** hw/sram_ctl_consts.svh ***
`ifndef SRC_SRAM_CTL_CONSTS_SVH
`define SRC_SRAM_CTL_CONSTS_SVH

// ----------------------------------------------------------------------
// Geometry of the attached memory
// ----------------------------------------------------------------------
`define SRC_ADDR_W 14
`define SRC_DATA_W 4

// ----------------------------------------------------------------------
// Timing figures in nanoseconds and the clock period
// ----------------------------------------------------------------------
`define SRC_CLK_NS 10
`define SRC_ACCESS_NS 25
`define SRC_WRITE_PULSE_NS 15
`define SRC_DATA_SETUP_NS 10
`define SRC_TURN_NS 10

// Least times round up to whole cycles.
`define SRC_ACCESS_CYC ((`SRC_ACCESS_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS)
`define SRC_WPULSE_CYC ((`SRC_WRITE_PULSE_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS)
`define SRC_TURN_CYC ((`SRC_TURN_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS)

`endif

// *** hw/src_pkg.sv ***
package src_pkg;
  // Controller sequence; Gray codes along idle-setup-strobe-hold-turn, but turn back to idle flips two bits.
  typedef enum logic [2:0] {
    SRC_IDLE = 3'b000,
    SRC_SETUP = 3'b001,
    SRC_STROBE = 3'b011,
    SRC_HOLD = 3'b010,
    SRC_TURN = 3'b110
  } src_state_t;
endpackage

// *** hw/src_sram_ctl.sv ***
`timescale 1ns/1ps
`include "sram_ctl_consts.svh"

// Host-side controller for an asynchronous 16K x 4 static memory.
module src_sram_ctl import src_pkg::*; #(
  parameter int ADDR_W = `SRC_ADDR_W,
  parameter int DATA_W = `SRC_DATA_W,
  // One selects the variant with an output drive control pin.
  parameter bit HAS_DRIVE_CTL = 1'b1,
  parameter int ACCESS_CYC = `SRC_ACCESS_CYC,
  parameter int WPULSE_CYC = `SRC_WPULSE_CYC,
  parameter int TURN_CYC = `SRC_TURN_CYC
) (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // User request port.
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_WRITE_I,
  input wire logic [ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [DATA_W-1:0] REQ_WDATA_I,
  // User answer port.
  output logic RSP_VALID_O,
  output logic [DATA_W-1:0] RSP_RDATA_O,
  // Memory pins; enables are low while this controller drives.
  output logic [ADDR_W-1:0] MEM_WORD_INDEX_O,
  output logic MEM_SELECT_N_O,
  output logic MEM_WRITE_N_O,
  output logic MEM_DRIVE_N_O,
  input wire logic [DATA_W-1:0] MEM_DQ_I,
  output logic [DATA_W-1:0] MEM_DQ_O,
  output logic [DATA_W-1:0] MEM_DQ_OE_N_O
);
  // Timer width; enough for the longest phase at the default timings.
  localparam int CW = 4;

  src_state_t state_ff, nxt_state; // Sequence state.
  logic [ADDR_W-1:0] addr_ff, nxt_addr; // Latched word index.
  logic [DATA_W-1:0] wdata_ff, nxt_wdata; // Latched write word.
  logic wr_ff, nxt_wr; // Latched direction.
  logic sel_n_ff, nxt_sel_n; // Select pin.
  logic we_n_ff, nxt_we_n; // Write strobe pin.
  logic oe_n_ff, nxt_oe_n; // Drive control pin.
  logic dq_en_ff, nxt_dq_en; // Own data drive.
  logic rsp_ff, nxt_rsp; // Answer pulse.
  logic [DATA_W-1:0] rdata_ff, nxt_rdata; // Captured read word.
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff; // Data pin synchroniser.
  logic t_load; // Timer load.
  logic [CW-1:0] t_count; // Timer count.
  logic t_done; // Timer expiry.

  // Cycle count helper. A count below one is raised to one, and a count
  // beyond the timer's range is held at its largest value, so a slow
  // memory grade with a short counter gives a wait cut to the largest count, never a
  // wrapped and far too short one.
  function automatic logic [CW-1:0] cyc(input int n);
    if (n < 1) begin
      cyc = CW'(1);
    end else if (n > (2 ** CW) - 1) begin
      cyc = {CW{1'b1}};
    end else begin
      cyc = CW'(n);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Phase timer
  // ----------------------------------------------------------------------
  src_wait_timer #(.CW(CW)) u_timer (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .load_i(t_load),
    .count_i(t_count),
    .done_o(t_done)
  );

  // ----------------------------------------------------------------------
  // Data pin synchroniser
  // ----------------------------------------------------------------------
  // The memory answers asynchronously, so its data passes two flops.
  // The word is taken long after it settled, so both flops hold one value.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end else begin
      dq_s1_ff <= MEM_DQ_I;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Sequence next-state logic
  // ----------------------------------------------------------------------
  // Every register keeps its value unless a state moves it; the answer
  // pulse and the timer load default low so that each lasts one cycle.
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_wr = wr_ff;
    nxt_sel_n = sel_n_ff;
    nxt_we_n = we_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_dq_en = dq_en_ff;
    nxt_rsp = 1'b0;
    nxt_rdata = rdata_ff;
    t_load = 1'b0;
    t_count = cyc(1);
    case (state_ff)
      SRC_IDLE: begin
        if (REQ_VALID_I) begin
          // address while idle
          // The index only moves here, with select and strobe both high.
          nxt_addr = REQ_ADDR_I;
          nxt_wdata = REQ_WDATA_I;
          nxt_wr = REQ_WRITE_I;
          nxt_state = SRC_SETUP;
        end
      end
      SRC_SETUP: begin
        // address settled first
        // The address has stood one cycle before select falls.
        nxt_sel_n = 1'b0;
        t_load = 1'b1;
        if (wr_ff) begin
          // write strobe early
          // Strobe falls with select, so the memory never drives.
          nxt_we_n = 1'b0;
          nxt_dq_en = 1'b1;
          t_count = cyc(WPULSE_CYC);
        end else begin
          // read gating
          // Drive control is only pulled on the variant that has it.
          nxt_oe_n = !HAS_DRIVE_CTL;
          // Two extra cycles cover the synchroniser delay.
          t_count = cyc(ACCESS_CYC + 2);
        end
        nxt_state = SRC_STROBE;
      end
      SRC_STROBE: begin
        // The timer holds the phase; the pins keep their levels until it expires.
        if (t_done) begin
          if (wr_ff) begin
            // strobe ends write
            // The strobe ends the write; data is still held for the hold time.
            nxt_we_n = 1'b1;
            // no read window
            // Without a drive control pin, select low with the strobe high is a
            // read, so select rises together with the strobe to avoid a fight.
            if (!HAS_DRIVE_CTL) begin
              nxt_sel_n = 1'b1;
            end
          end else begin
            nxt_rdata = dq_s2_ff;
            nxt_rsp = 1'b1;
            nxt_oe_n = 1'b1;
          end
          nxt_state = SRC_HOLD;
        end
      end
      SRC_HOLD: begin
        // Select rises after the strobe on the drive control variant; data released here.
        nxt_sel_n = 1'b1;
        nxt_dq_en = 1'b0;
        // A write reports completion here; a read has already answered.
        nxt_rsp = wr_ff;
        t_load = 1'b1;
        t_count = cyc(TURN_CYC);
        nxt_state = SRC_TURN;
      end
      SRC_TURN: begin
        // bus turnaround
        // Wait for the memory output to float before a new cycle.
        if (t_done) begin
          nxt_state = SRC_IDLE;
        end
      end
      default: begin
        nxt_state = SRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_ff <= SRC_IDLE;
      addr_ff <= '0;
      wdata_ff <= '0;
      wr_ff <= 1'b0;
      sel_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      dq_en_ff <= 1'b0;
      rsp_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      wr_ff <= nxt_wr;
      sel_n_ff <= nxt_sel_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      dq_en_ff <= nxt_dq_en;
      rsp_ff <= nxt_rsp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // All pin outputs come straight from flops, so the memory never sees a
  // glitch on a strobe while the next-state logic settles.
  // full index width
  assign MEM_WORD_INDEX_O = addr_ff;
  assign MEM_SELECT_N_O = sel_n_ff;
  assign MEM_WRITE_N_O = we_n_ff;
  assign MEM_DRIVE_N_O = oe_n_ff;
  assign MEM_DQ_O = wdata_ff;
  assign MEM_DQ_OE_N_O = {DATA_W{!dq_en_ff}};
  assign REQ_READY_O = (state_ff == SRC_IDLE);
  assign RSP_VALID_O = rsp_ff;
  assign RSP_RDATA_O = rdata_ff;
endmodule

// *** hw/src_wait_timer.sv ***
`timescale 1ns/1ps
`include "sram_ctl_consts.svh"

// Down counter that reports when a loaded wait has elapsed.
module src_wait_timer import src_pkg::*; #(
  parameter int CW = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Load request and count.
  input wire logic load_i,
  input wire logic [CW-1:0] count_i,
  // Expiry level.
  output logic done_o
);
  logic [CW-1:0] cnt_ff; // Remaining cycles.
  logic [CW-1:0] nxt_cnt; // Next remaining cycles.

  // ----------------------------------------------------------------------
  // Next-count logic
  // ----------------------------------------------------------------------
  // A load wins over counting, so back-to-back phases never merge.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load_i) begin
      nxt_cnt = count_i;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  // Register stage only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // The wait ends when the counter has reached its last cycle.
  assign done_o = (cnt_ff <= CW'(1)) && !load_i;
endmodule

// *** verification/src_sram_ctl_checker.sv ***
`timescale 1ns/1ps
// Watches the memory pins and the request handshake of the controller.
module src_sram_ctl_checker #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 4,
  parameter bit HAS_DRIVE_CTL = 1'b1
) (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // User side.
  input wire logic REQ_VALID_I,
  input wire logic REQ_READY_O,
  input wire logic REQ_WRITE_I,
  input wire logic RSP_VALID_O,
  // Memory pins.
  input wire logic [ADDR_W-1:0] MEM_WORD_INDEX_O,
  input wire logic MEM_SELECT_N_O,
  input wire logic MEM_WRITE_N_O,
  input wire logic MEM_DRIVE_N_O,
  input wire logic [DATA_W-1:0] MEM_DQ_OE_N_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  a_bus_no_fight: assert property (!MEM_SELECT_N_O && MEM_WRITE_N_O && !MEM_DRIVE_N_O
    |-> &MEM_DQ_OE_N_O) else $error("controller drives data during a read");
  a_write_drives: assert property (!MEM_WRITE_N_O |-> !MEM_SELECT_N_O && MEM_DRIVE_N_O
    && MEM_DQ_OE_N_O == '0) else $error("write strobe without select or data");
  a_read_gate: assert property (!MEM_DRIVE_N_O |-> !MEM_SELECT_N_O && MEM_WRITE_N_O)
    else $error("drive control low outside a read");
  a_pulse_len: assert property ($fell(MEM_WRITE_N_O) |-> !MEM_WRITE_N_O [*2]
    ##1 MEM_WRITE_N_O) else $error("write strobe width wrong");
  a_select_last: assert property ($rose(MEM_WRITE_N_O) |->
    (HAS_DRIVE_CTL ? !MEM_SELECT_N_O : MEM_SELECT_N_O) ##1 MEM_SELECT_N_O)
    else $error("select not released in step with the strobe");
  a_addr_hold: assert property (!MEM_SELECT_N_O && !MEM_WRITE_N_O ##1
    !MEM_SELECT_N_O && !MEM_WRITE_N_O |-> $stable(MEM_WORD_INDEX_O))
    else $error("address moved during a write");
  a_access_wait: assert property ($fell(MEM_DRIVE_N_O) |-> !MEM_DRIVE_N_O [*3]
    ##[1:12] RSP_VALID_O) else $error("read answered too early or never");
  a_take_select: assert property (REQ_VALID_I && REQ_READY_O |-> ##[1:4] !MEM_SELECT_N_O)
    else $error("request taken but memory not selected");
  a_read_no_write: assert property (REQ_VALID_I && REQ_READY_O && !REQ_WRITE_I
    |=> MEM_WRITE_N_O [*8]) else $error("write strobe during a read");
  a_answer_gap: assert property (RSP_VALID_O |-> !REQ_READY_O ##1 !RSP_VALID_O)
    else $error("answer pulse too long or ready too soon");
  c_write: cover property ($rose(MEM_WRITE_N_O));
  c_read: cover property ($fell(MEM_DRIVE_N_O));
  c_answer: cover property (RSP_VALID_O);
endmodule
bind src_sram_ctl src_sram_ctl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
  .HAS_DRIVE_CTL(HAS_DRIVE_CTL)) i_chk (
  .CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .REQ_VALID_I(REQ_VALID_I),
  .REQ_READY_O(REQ_READY_O), .REQ_WRITE_I(REQ_WRITE_I), .RSP_VALID_O(RSP_VALID_O),
  .MEM_WORD_INDEX_O(MEM_WORD_INDEX_O), .MEM_SELECT_N_O(MEM_SELECT_N_O),
  .MEM_WRITE_N_O(MEM_WRITE_N_O), .MEM_DRIVE_N_O(MEM_DRIVE_N_O),
  .MEM_DQ_OE_N_O(MEM_DQ_OE_N_O));

// *** verification/src_sram_model.sv ***
`timescale 1ns/1ps
// Unclocked 16K x 4 memory with a shared data bus and drive control.
module src_sram_model #(
  parameter int ACCESS_NS = 25
) (
  // Address and strobes from the controller.
  input wire logic [13:0] word_index_i,
  input wire logic select_n_i,
  input wire logic write_n_i,
  input wire logic drive_n_i,
  // Controller side of the shared data pins.
  input wire logic [3:0] ctl_dq_i,
  input wire logic [3:0] ctl_oe_n_i,
  // Resolved level of the shared data pins.
  output logic [3:0] dq_o
);
  logic [3:0] cells [16384]; // storage words
  logic [3:0] last_q = 4'h0; // Last driven level; a floating bus shows its inverse.
  logic mem_drv, acc_ok, wr_on;
  assign mem_drv = !select_n_i && write_n_i && !drive_n_i;
  // data only after one access time
  assign #(ACCESS_NS) acc_ok = mem_drv;
  assign dq_o = (~ctl_oe_n_i & ctl_dq_i) |
    (ctl_oe_n_i & ((mem_drv && acc_ok) ? cells[word_index_i] : ~last_q));
  // Only settled levels are remembered; recording the floating inverse would
  // feed back into the bus and spin forever in zero time.
  always @(dq_o) if ((mem_drv && acc_ok) || !ctl_oe_n_i[0]) last_q = dq_o;
  // first rising strobe stores the word
  assign wr_on = !select_n_i && !write_n_i;
  always @(negedge wr_on) cells[word_index_i] = dq_o;
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps
`include "sram_ctl_consts.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module tb;
  logic clk, rst, valid, write, ready, rsp_v, sel_n, we_n, drv_n;
  logic [13:0] addr, idx;
  logic [3:0] wdata, rdata, dq_in, dq_out, oe_n;
  // Second controller built without the drive control pin, on its own memory.
  logic ready_b, rsp_v_b, sel_n_b, we_n_b, drv_n_b;
  logic [13:0] idx_b;
  logic [3:0] rdata_b, dq_in_b, dq_out_b, oe_n_b;
  logic [3:0] ref_mem [int]; // Reference memory of written words.
  int a_q[$];
  int err_count = 0;
  int samples_checked = 0;
  src_sram_ctl i_dut (.CLOCK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(valid), .REQ_READY_O(ready),
    .REQ_WRITE_I(write), .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata), .RSP_VALID_O(rsp_v),
    .RSP_RDATA_O(rdata), .MEM_WORD_INDEX_O(idx), .MEM_SELECT_N_O(sel_n),
    .MEM_WRITE_N_O(we_n), .MEM_DRIVE_N_O(drv_n), .MEM_DQ_I(dq_in), .MEM_DQ_O(dq_out),
    .MEM_DQ_OE_N_O(oe_n));
  src_sram_model i_mem (.word_index_i(idx), .select_n_i(sel_n), .write_n_i(we_n),
    .drive_n_i(drv_n), .ctl_dq_i(dq_out), .ctl_oe_n_i(oe_n), .dq_o(dq_in));
  src_sram_ctl #(.HAS_DRIVE_CTL(1'b0)) i_dut_b (.CLOCK_I(clk), .SYS_RST_I(rst),
    .REQ_VALID_I(valid), .REQ_READY_O(ready_b), .REQ_WRITE_I(write), .REQ_ADDR_I(addr),
    .REQ_WDATA_I(wdata), .RSP_VALID_O(rsp_v_b), .RSP_RDATA_O(rdata_b),
    .MEM_WORD_INDEX_O(idx_b), .MEM_SELECT_N_O(sel_n_b), .MEM_WRITE_N_O(we_n_b),
    .MEM_DRIVE_N_O(drv_n_b), .MEM_DQ_I(dq_in_b), .MEM_DQ_O(dq_out_b),
    .MEM_DQ_OE_N_O(oe_n_b));
  // A memory without the drive control pin behaves as if that pin were held low.
  src_sram_model i_mem_b (.word_index_i(idx_b), .select_n_i(sel_n_b), .write_n_i(we_n_b),
    .drive_n_i(1'b0), .ctl_dq_i(dq_out_b), .ctl_oe_n_i(oe_n_b), .dq_o(dq_in_b));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One request: wait to be taken, then time and check the answer.
  task automatic xfer(input bit w, input int a, input logic [3:0] d);
    int n;
    @(posedge clk);
    #1 valid = 1'b1;
    write = w;
    addr = a[13:0];
    wdata = d;
    n = 0;
    do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 50);
    `CHK("ready", 1'b1, ready)
    `CHK("ready b", 1'b1, ready_b)
    @(posedge clk);
    #1 valid = 1'b0;
    addr = 14'($urandom); // Idle inputs carry noise that must be ignored.
    n = 0;
    do begin @(negedge clk); n++; end while (rsp_v !== 1'b1 && n < 40);
    `CHK("latency", (w ? 3 + `SRC_WPULSE_CYC : 4 + `SRC_ACCESS_CYC), n)
    `CHK("answer b", 1'b1, rsp_v_b)
    `CHK("no drive pin", 1'b1, drv_n_b)
    if (!w) begin
      `CHK("read word", ref_mem[a], rdata)
      `CHK("read word b", ref_mem[a], rdata_b)
    end else begin
      ref_mem[a] = d;
    end
    @(negedge clk);
    `CHK("pulse", 1'b0, rsp_v)
  endtask
  initial begin
    rst = 1'b1;
    valid = 1'b0;
    write = 1'b0;
    addr = '0;
    wdata = '0;
    void'($urandom(32'h7dad));
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    // Edge addresses and polarity patterns, written then read straight back.
    foreach (a_q[i]) ;
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, (k[0] ? 16383 : 0), {k[2], k[1], ~k[1], k[2]});
      xfer(1'b0, (k[0] ? 16383 : 0), 4'h0);
    end
    // Random words; repeats in the list exercise overwrite.
    for (int k = 0; k < 24; k++) begin
      a_q.push_back($urandom_range(16383));
      xfer(1'b1, a_q[k], 4'($urandom));
    end
    xfer(1'b1, a_q[0], ~ref_mem[a_q[0]]);
    foreach (a_q[i]) xfer(1'b0, a_q[i], 4'h0);
    // A reset in mid-run must not disturb stored words.
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("select in reset", 1'b1, sel_n)
    `CHK("data drive in reset", 4'hf, oe_n)
    @(posedge clk);
    #1 rst = 1'b0;
    foreach (a_q[i]) xfer(1'b0, a_q[i], 4'h0);
    complete_run();
  end
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule
